// ### host_model.sv
// Host controller model on the register port.
// Assumes read data arrives one cycle after the strobe.
`timescale 1ns/1ps
module host_model (
    // Register port
    input  wire logic                       CLK,
    output thermal_regs_pkg::reg_req_s      REQ,
    input  wire logic [7:0]                 RDATA,
    input  wire logic                       RVALID
);
    import thermal_regs_pkg::*;
    initial REQ = '0;
    // Callers pass limits below the low limit and may set reserved bits
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge CLK);
        #1 REQ = '{1'b1, 1'b0, a, d};
        @(posedge CLK);
        #1 REQ.wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge CLK);
        #1 REQ = '{1'b0, 1'b1, a, 8'h00};
        @(posedge CLK);
        #1 REQ.rd = 1'b0;
        d = RVALID ? RDATA : 8'hXX;
    endtask
endmodule

// ### thermal_limit_resolution_regs.sv
// Critical low limit pair, thermal format and resolution register.
// Assumes synchronous single-cycle register requests from the bus front end
// and a raw 16-bit conversion result from the analog sensor path.
`timescale 1ns/1ps

// Operation
// RULE1: Critical low pair at 0x22/0x23, resets zero
// RULE2: Host keeps critical low below low limit
// RULE3: Thermal values are two bytes, low first
// RULE4: Host writes zero into reserved bits; the bench writes ones into them
// RULE5: Reserved bits always read back zero; after a resolution change 0x31 keeps old fraction bits until the next sample
// RULE6: Eleven bits signed, quarter degree steps
// RULE7: Default layout: low 7:2, high 4:0
// RULE8: Negative values in two's complement
// RULE9: Two-bit resolution field, reset 01
// RULE10: Conversion time 34, 68, 136 ms
// RULE11: Nine-bit mode: low bits 2:0 reserved
// RULE12: Eleven-bit mode: bit 1 is eighth degree
// RULE13: Twelve-bit mode: all low bits used
// RULE14: Latest result in read-only pair 0x31
// RULE15: Resolution bits 7:2 reserved, read zero
module thermal_limit_resolution_regs #(
    parameter int CONV_CYC_9  = thermal_regs_pkg::CONV_CYC_9BIT,
    parameter int CONV_CYC_10 = thermal_regs_pkg::CONV_CYC_10BIT,
    parameter int CONV_CYC_12 = thermal_regs_pkg::CONV_CYC_11_12
) (
    // Clock and reset
    input  wire logic                       CLK,
    input  wire logic                       RESET,
    // Register port
    input  wire thermal_regs_pkg::reg_req_s REQ,
    output logic [7:0]                      RDATA,
    output logic                            RVALID,
    // Sensor path
    input  wire logic [15:0]                RAW_TEMP,
    output logic [15:0]                     CRIT_LOW_WORD,
    output logic [1:0]                      RES_SEL,
    output logic                            CONV_DONE
);
    import thermal_regs_pkg::*;

    regs_s       cur_ff;
    regs_s       nxt_s;
    logic [7:0]  lsb_mask;
    logic [31:0] conv_len;

    // Low byte mask follows the resolution so unused fractions of the limit read zero; results are trimmed when sampled
    always_comb begin
        case (cur_ff.res_sel)
            RES_9BIT:  lsb_mask = LSB_MASK_9BIT;   // RULE11
            RES_10BIT: lsb_mask = LSB_MASK_10BIT;  // RULE7
            RES_11BIT: lsb_mask = LSB_MASK_11BIT;  // RULE12
            default:   lsb_mask = LSB_MASK_12BIT;  // RULE13
        endcase
        case (cur_ff.res_sel)
            RES_9BIT:  conv_len = 32'(CONV_CYC_9);   // RULE10
            RES_10BIT: conv_len = 32'(CONV_CYC_10);  // RULE10
            default:   conv_len = 32'(CONV_CYC_12);  // RULE10
        endcase
    end

    always_comb begin
        nxt_s           = cur_ff;
        nxt_s.rvalid    = 1'b0;
        nxt_s.conv_done = 1'b0;
        // Conversion period; result sampled at the end of each period
        if (cur_ff.conv_cnt >= conv_len - 32'd1) begin
            nxt_s.conv_cnt  = 32'd0;
            nxt_s.conv_done = 1'b1;
            // High byte cut to bits 4:0, fractions trimmed to the resolution
            nxt_s.sensed = {RAW_TEMP[15:8] & MSB_VALUE_MASK,
                            RAW_TEMP[7:0] & lsb_mask};  // RULE14 RULE8 RULE6
        end else begin
            nxt_s.conv_cnt = cur_ff.conv_cnt + 32'd1;
        end
        // Writes; high byte and resolution reserved bits are masked, the low byte is stored whole
        if (REQ.wr) begin
            if (REQ.addr == CRIT_LOW_LIMIT_LSB_ADDR) begin
                nxt_s.crit_low_lsb = REQ.wdata & LSB_MASK_12BIT;  // RULE1 RULE3
            end else if (REQ.addr == CRIT_LOW_LIMIT_MSB_ADDR) begin
                nxt_s.crit_low_msb = REQ.wdata & MSB_VALUE_MASK;  // RULE1 RULE5
            end else if (REQ.addr == SENSOR_RESOLUTION_CFG_ADDR) begin
                nxt_s.res_sel = res_sel_e'(REQ.wdata[RES_SEL_LSB +: RES_SEL_W]);  // RULE9 RULE15
            end
        end
        // Reads; unmapped addresses return zero
        if (REQ.rd) begin
            nxt_s.rvalid = 1'b1;
            if (REQ.addr == CRIT_LOW_LIMIT_LSB_ADDR) begin
                nxt_s.rdata = cur_ff.crit_low_lsb & lsb_mask;  // RULE5
            end else if (REQ.addr == CRIT_LOW_LIMIT_MSB_ADDR) begin
                nxt_s.rdata = cur_ff.crit_low_msb & MSB_VALUE_MASK;  // RULE5
            end else if (REQ.addr == SENSOR_RESOLUTION_CFG_ADDR) begin
                nxt_s.rdata = {6'h00, cur_ff.res_sel};  // RULE15
            end else if (REQ.addr == SENSED_TEMP_LSB_ADDR) begin
                nxt_s.rdata = cur_ff.sensed[7:0];  // RULE14
            end else if (REQ.addr == SENSED_TEMP_MSB_ADDR) begin
                nxt_s.rdata = cur_ff.sensed[15:8];  // RULE14
            end else begin
                nxt_s.rdata = 8'h00;
            end
        end
        // Limit word presented to the comparators; host keeps it ordered
        nxt_s.crit_low_word = {nxt_s.crit_low_msb, nxt_s.crit_low_lsb};  // RULE2 RULE3
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            cur_ff.crit_low_lsb  <= CRIT_LOW_LSB_RESET;
            cur_ff.crit_low_msb  <= CRIT_LOW_MSB_RESET;
            cur_ff.res_sel       <= res_sel_e'(RES_SEL_RESET);
            cur_ff.sensed        <= 16'h0000;
            cur_ff.crit_low_word <= 16'h0000;
            cur_ff.rdata         <= 8'h00;
            cur_ff.rvalid        <= 1'b0;
            cur_ff.conv_done     <= 1'b0;
            cur_ff.conv_cnt      <= 32'h00000000;
        end else begin
            cur_ff <= nxt_s;
        end
    end

    assign RDATA         = cur_ff.rdata;
    assign RVALID        = cur_ff.rvalid;
    assign CRIT_LOW_WORD = cur_ff.crit_low_word;
    assign RES_SEL       = cur_ff.res_sel;
    assign CONV_DONE     = cur_ff.conv_done;

endmodule

// ### thermal_limit_resolution_regs_tb.sv
// Bench for the thermal register block.
// Assumes short conversion periods set by parameter.
`timescale 1ns/1ps
module thermal_limit_resolution_regs_tb;
    import thermal_regs_pkg::*;
    logic CLK = 1'b0;
    logic RESET = 1'b1;
    logic [15:0] RAW_TEMP = 16'hFFFF;
    reg_req_s REQ;
    logic [7:0] RDATA, d;
    logic RVALID, CONV_DONE;
    logic [15:0] CRIT_LOW_WORD;
    logic [1:0] RES_SEL;
    logic [7:0] lmask [4] = '{8'hF8, 8'hFC, 8'hFE, 8'hFF};
    int lim [4] = '{10, 20, 40, 40};
    int n_errors = 0, compares = 0, n;
    always #12.5 CLK = ~CLK;
    host_model HOST (.CLK(CLK), .REQ(REQ), .RDATA(RDATA), .RVALID(RVALID));
    thermal_limit_resolution_regs #(.CONV_CYC_9(10), .CONV_CYC_10(20), .CONV_CYC_12(40)) DUT (.CLK(CLK),
        .RESET(RESET), .REQ(REQ), .RDATA(RDATA), .RVALID(RVALID), .RAW_TEMP(RAW_TEMP),
        .CRIT_LOW_WORD(CRIT_LOW_WORD), .RES_SEL(RES_SEL), .CONV_DONE(CONV_DONE));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        HOST.rd(a, d);
        check({8'h00, d}, {8'h00, e});
    endtask
    task automatic to_done(output int c);
        c = 0;
        do begin
            @(posedge CLK);
            #1 c++;
        end while (CONV_DONE !== 1'b1 && c < 200);
    endtask
    task automatic close_out;
        $display("compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        #100000 n_errors++;
        close_out;
    end
    initial begin
        repeat (5) @(posedge CLK);
        #1 RESET = 1'b0;
        rchk(8'h22, 8'h00);
        rchk(8'h23, 8'h00);
        rchk(8'h24, 8'h01);
        $display("test reset done");
        HOST.wr(8'h23, 8'h1D);
        HOST.wr(8'h22, 8'h80);
        check(CRIT_LOW_WORD, 16'h1D80);
        HOST.wr(8'h23, 8'hFF);
        HOST.wr(8'h22, 8'hFF);
        rchk(8'h23, 8'h1F);
        rchk(8'h22, 8'hFC);
        HOST.wr(8'h24, 8'hFF);
        rchk(8'h24, 8'h03);
        rchk(8'h40, 8'h00);
        $display("test format done");
        // Period measured between two pulses, since a change lands mid-count
        for (int r = 0; r < 4; r++) begin
            HOST.wr(8'h24, 8'(r));
            rchk(8'h22, lmask[r]);
            to_done(n);
            to_done(n);
            check(16'(n), 16'(lim[r]));
            rchk(8'h31, lmask[r]);
            rchk(8'h32, 8'h1F);
        end
        $display("test conversion done");
        close_out;
    end
endmodule

// ### thermal_regs_pkg.sv
// Package for the thermal limit and resolution register block.
// Assumes a byte-wide register port driven by the sideband bus front end.
package thermal_regs_pkg;

    // Register byte addresses
    localparam logic [7:0] CRIT_LOW_LIMIT_LSB_ADDR    = 8'h22;
    localparam logic [7:0] CRIT_LOW_LIMIT_MSB_ADDR    = 8'h23;
    localparam logic [7:0] SENSOR_RESOLUTION_CFG_ADDR = 8'h24;
    localparam logic [7:0] SENSED_TEMP_LSB_ADDR       = 8'h31;
    localparam logic [7:0] SENSED_TEMP_MSB_ADDR       = 8'h32;

    // Reset values
    localparam logic [7:0] CRIT_LOW_LSB_RESET = 8'h00;
    localparam logic [7:0] CRIT_LOW_MSB_RESET = 8'h00;
    localparam logic [1:0] RES_SEL_RESET      = 2'h1;

    // Field layout of a thermal pair and the resolution register
    localparam logic [7:0] MSB_VALUE_MASK = 8'h1F;
    localparam int         RES_SEL_LSB    = 0;
    localparam int         RES_SEL_W      = 2;

    // Resolution codes
    typedef enum logic [1:0] {
        RES_9BIT  = 2'b00,
        RES_10BIT = 2'b01,
        RES_11BIT = 2'b10,
        RES_12BIT = 2'b11
    } res_sel_e;

    // Low byte masks per resolution
    localparam logic [7:0] LSB_MASK_9BIT  = 8'hF8;
    localparam logic [7:0] LSB_MASK_10BIT = 8'hFC;
    localparam logic [7:0] LSB_MASK_11BIT = 8'hFE;
    localparam logic [7:0] LSB_MASK_12BIT = 8'hFF;

    // Conversion times
    localparam int CLK_HZ          = 40000000;
    localparam int CONV_MS_9BIT    = 34;
    localparam int CONV_MS_10BIT   = 68;
    localparam int CONV_MS_11_12   = 136;
    localparam int CONV_CYC_9BIT   = (CLK_HZ / 1000) * CONV_MS_9BIT;
    localparam int CONV_CYC_10BIT  = (CLK_HZ / 1000) * CONV_MS_10BIT;
    localparam int CONV_CYC_11_12  = (CLK_HZ / 1000) * CONV_MS_11_12;

    // Register bus request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

    // Block state
    typedef struct packed {
        logic [7:0]  crit_low_lsb;
        logic [7:0]  crit_low_msb;
        res_sel_e    res_sel;
        logic [15:0] sensed;
        logic [15:0] crit_low_word;
        logic [7:0]  rdata;
        logic        rvalid;
        logic        conv_done;
        logic [31:0] conv_cnt;
    } regs_s;

endpackage

// ### thermal_regs_props.sv
// Port checker for the thermal register block.
// Assumes the bench never writes and reads one address in a cycle.
`timescale 1ns/1ps
module thermal_regs_props (
    // Watched ports
    input wire logic                       CLK,
    input wire logic                       RESET,
    input wire thermal_regs_pkg::reg_req_s REQ,
    input wire logic [7:0]                 RDATA,
    input wire logic                       RVALID,
    input wire logic [15:0]                CRIT_LOW_WORD,
    input wire logic [1:0]                 RES_SEL,
    input wire logic                       CONV_DONE
);
    import thermal_regs_pkg::*;
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    a_read_answered: assert property (REQ.rd |=> RVALID) else $error("read not answered");
    a_valid_cause: assert property (RVALID |-> $past(REQ.rd)) else $error("stray read answer");
    a_lsb_write: assert property (REQ.wr && REQ.addr == 8'h22 |=>
        CRIT_LOW_WORD[7:0] == $past(REQ.wdata)) else $error("low byte lost");
    a_msb_write: assert property (REQ.wr && REQ.addr == 8'h23 |=>
        CRIT_LOW_WORD[15:8] == ($past(REQ.wdata) & 8'h1F)) else $error("high byte wrong");
    a_res_write: assert property (REQ.wr && REQ.addr == 8'h24 |=>
        RES_SEL == $past(REQ.wdata[1:0])) else $error("resolution not set");
    a_res_read: assert property (REQ.rd && REQ.addr == 8'h24 |=>
        RDATA == {6'h00, $past(RES_SEL)}) else $error("resolution read wrong");
    a_msb_read: assert property (REQ.rd && REQ.addr == 8'h23 |=>
        RDATA == $past(CRIT_LOW_WORD[15:8])) else $error("high byte read wrong");
    a_done_pulse: assert property (CONV_DONE |=> !CONV_DONE) else $error("done too long");
endmodule
bind thermal_limit_resolution_regs thermal_regs_props u_props (.CLK(CLK), .RESET(RESET), .REQ(REQ),
    .RDATA(RDATA), .RVALID(RVALID), .CRIT_LOW_WORD(CRIT_LOW_WORD), .RES_SEL(RES_SEL), .CONV_DONE(CONV_DONE));
